// >>> hdl/conv_reg_if.sv
// Converter register front end: three byte registers on the core SFR bus driving the analog converter.
// Assumes single-cycle SFR write and read strobes from the core on i_clk_sys.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - 12-bit mode: output updates on low-byte write
// - Code right-justified: low byte, high nibble
// - Byte mode: low byte to MSBs, LSBs zero
// - Control bit 4 selects output pin
// - Control bit 2 selects output range
// - Clear bit low holds data registers zero
// - Control bit 0 low powers converter down
// - Control bits 7 to 5 reserved, ignored
// - Data at FBH, FCH, reset zero, bytes
module conv_reg_if (
	input  wire logic                   i_clk_sys, // Core clock
	input  wire logic                   i_nrst,    // Async reset, active low
	input  wire conv_reg_pkg::sfr_req_s i_req,     // SFR write/read request
	output logic [7:0]                  o_rdata,   // Read data, one cycle after read
	output logic                        o_rvalid,  // Read data valid pulse
	output conv_reg_pkg::conv_ctrl_s    o_conv     // Converter controls
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire logic sel_low  = i_req.addr == conv_reg_pkg::ADDR_CODE_LOW;
	wire logic sel_high = i_req.addr == conv_reg_pkg::ADDR_CODE_HIGH;
	wire logic sel_ctrl = i_req.addr == conv_reg_pkg::ADDR_CONTROL;
	wire logic wr_low   = i_req.wr && sel_low;
	wire logic wr_high  = i_req.wr && sel_high;
	wire logic wr_ctrl  = i_req.wr && sel_ctrl;

	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] low_q, low_d;
	logic [7:0] high_q, high_d;
	logic [11:0] code_d;
	logic [7:0] rdata_d;
	conv_reg_pkg::conv_ctrl_s conv_d;

	// Reserved bits never stored, read as zero
	assign ctrl_d = wr_ctrl ? (i_req.wdata & conv_reg_pkg::CONTROL_USED_MASK) : ctrl_q;

	// Clear level holds data at zero; uses the new control value so clearing is immediate
	wire logic clear_n = ctrl_d[conv_reg_pkg::BIT_CODE_CLEAR_N];
	assign low_d  = !clear_n ? conv_reg_pkg::RESET_CODE : (wr_low ? i_req.wdata : low_q);
	assign high_d = !clear_n ? conv_reg_pkg::RESET_CODE
		: (wr_high ? (i_req.wdata & {4'h0, conv_reg_pkg::HIGH_NIBBLE_MASK}) : high_q);

	// ----------------------------------------
	// Code formation
	// ----------------------------------------
	wire logic byte_mode = ctrl_d[conv_reg_pkg::BIT_BYTE_MODE];
	wire logic [11:0] code_word = byte_mode ? {low_d, 4'h0}
		: {high_d[3:0], low_d};
	// Latched code moves only on low-byte write or clear, so a high write alone is invisible
	assign code_d = !clear_n ? 12'h000 : (wr_low ? code_word : o_conv.code);

	always_comb begin
		conv_d.power_down    = !ctrl_d[conv_reg_pkg::BIT_POWER_ENABLE];
		conv_d.range_supply  = ctrl_d[conv_reg_pkg::BIT_RANGE_SELECT];
		conv_d.pin_alternate = ctrl_d[conv_reg_pkg::BIT_PIN_SELECT];
		conv_d.code          = code_d;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	assign rdata_d = sel_low ? low_q : (sel_high ? high_q : (sel_ctrl ? ctrl_q : 8'h00));
	// Idle bus returns zero so a stale byte is never taken for fresh data
	wire logic [7:0] rdata_out = i_req.rd ? rdata_d : 8'h00;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q <= conv_reg_pkg::RESET_CONTROL;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			low_q  <= conv_reg_pkg::RESET_CODE;
			high_q <= conv_reg_pkg::RESET_CODE;
		end else begin
			low_q  <= low_d;
			high_q <= high_d;
		end
	end

	// Converter sees only registered controls, never a decode glitch
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_conv <= conv_reg_pkg::RESET_CONV;
		end else begin
			o_conv <= conv_d;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata  <= conv_reg_pkg::RESET_RDATA;
			o_rvalid <= 1'b0;
		end else begin
			o_rdata  <= rdata_out;
			o_rvalid <= i_req.rd;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_low_write_12;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(wr_low && !byte_mode && clear_n) |=> (o_conv.code == {high_q[3:0], low_q});
	endproperty
	a_low_write_12: assert property (p_low_write_12) else $error("12-bit code not applied on low write");

	property p_high_no_update;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(!wr_low && clear_n && !wr_ctrl) |=> $stable(o_conv.code);
	endproperty
	a_high_no_update: assert property (p_high_no_update) else $error("Code changed without low write");

	property p_byte_mode;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(wr_low && byte_mode && clear_n) |=> (o_conv.code[3:0] == 4'h0 && o_conv.code[11:4] == $past(i_req.wdata));
	endproperty
	a_byte_mode: assert property (p_byte_mode) else $error("Byte mode code wrong");

	property p_pin;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		1'b1 |=> (o_conv.pin_alternate == ctrl_q[4]);
	endproperty
	a_pin: assert property (p_pin) else $error("Pin select mismatch");

	property p_range;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		1'b1 |=> (o_conv.range_supply == ctrl_q[2]);
	endproperty
	a_range: assert property (p_range) else $error("Range select mismatch");

	property p_clear;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		!ctrl_q[1] |-> (low_q == 8'h00 && high_q == 8'h00 && o_conv.code == 12'h000);
	endproperty
	a_clear: assert property (p_clear) else $error("Data not held clear");

	property p_power;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		1'b1 |=> (o_conv.power_down == !ctrl_q[0]);
	endproperty
	a_power: assert property (p_power) else $error("Power-down mismatch");

	property p_reserved;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		ctrl_q[7:5] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved control bits set");

	property p_read_ctrl;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(i_req.rd && sel_ctrl) |=> (o_rvalid && o_rdata == $past(ctrl_q));
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("Control readback wrong");

	property p_nibble;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		high_q[7:4] == 4'h0;
	endproperty
	a_nibble: assert property (p_nibble) else $error("High nibble stored");

	property p_ctrl_write;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		wr_ctrl |=> (ctrl_q == ($past(i_req.wdata) & conv_reg_pkg::CONTROL_USED_MASK));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("Control write lost");

	property p_low_write_data;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(wr_low && clear_n) |=> (low_q == $past(i_req.wdata));
	endproperty
	a_low_write_data: assert property (p_low_write_data) else $error("Low code write lost");

	property p_read_low;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(i_req.rd && sel_low) |=> (o_rvalid && o_rdata == $past(low_q));
	endproperty
	a_read_low: assert property (p_read_low) else $error("Low code readback wrong");

	property p_read_high;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(i_req.rd && sel_high) |=> (o_rvalid && o_rdata == $past(high_q));
	endproperty
	a_read_high: assert property (p_read_high) else $error("High code readback wrong");

	property p_read_other;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(i_req.rd && !sel_low && !sel_high && !sel_ctrl) |=> (o_rvalid && o_rdata == 8'h00);
	endproperty
	a_read_other: assert property (p_read_other) else $error("Unmapped read not zero");

	property p_rvalid;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		!i_req.rd |=> (!o_rvalid && o_rdata == 8'h00);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("Read data without read");

	property p_byte_high;
		@(posedge i_clk_sys) disable iff (!i_nrst)
		(wr_high && byte_mode) |=> $stable(o_conv.code);
	endproperty
	a_byte_high: assert property (p_byte_high) else $error("High write changed byte mode code");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	c_low12:     cover property (@(posedge i_clk_sys) disable iff (!i_nrst) wr_low && !byte_mode && clear_n);
	c_byte:      cover property (@(posedge i_clk_sys) disable iff (!i_nrst) wr_low && byte_mode && clear_n);
	c_clear:     cover property (@(posedge i_clk_sys) disable iff (!i_nrst) wr_ctrl && !i_req.wdata[1]);
	c_high_byte: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) wr_high && byte_mode);
	c_read_low:  cover property (@(posedge i_clk_sys) disable iff (!i_nrst) i_req.rd && sel_low);
endmodule

`default_nettype wire

// >>> hdl/conv_reg_pkg.sv
// Package for the converter register front end: addresses, field positions, reset values, carriers.
// Assumes a byte-wide special-function-register bus on the core clock.
`default_nettype none
package conv_reg_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CODE_LOW  = 8'hfb;
	localparam logic [7:0] ADDR_CODE_HIGH = 8'hfc;
	localparam logic [7:0] ADDR_CONTROL   = 8'hfd;
	// ----------------------------------------
	// Control fields and reset values
	// ----------------------------------------
	localparam int unsigned BIT_POWER_ENABLE = 0;
	localparam int unsigned BIT_CODE_CLEAR_N = 1;
	localparam int unsigned BIT_RANGE_SELECT = 2;
	localparam int unsigned BIT_BYTE_MODE    = 3;
	localparam int unsigned BIT_PIN_SELECT   = 4;
	localparam logic [7:0]  CONTROL_USED_MASK = 8'h1f;
	localparam logic [7:0]  RESET_CONTROL     = 8'h00;
	localparam logic [7:0]  RESET_CODE        = 8'h00;
	localparam logic [7:0]  RESET_RDATA       = 8'h00;
	localparam logic [3:0]  HIGH_NIBBLE_MASK  = 4'hf;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	typedef struct packed {
		logic        power_down;
		logic        range_supply;
		logic        pin_alternate;
		logic [11:0] code;
	} conv_ctrl_s;

	// Control resets to zero, so the converter starts powered down
	localparam conv_ctrl_s RESET_CONV = '{power_down: 1'b1, range_supply: 1'b0, pin_alternate: 1'b0, code: 12'h000};
endpackage

`default_nettype wire

// >>> tb/conv_core_model.sv
// Behavioural model of the analog converter core behind the register front end.
// Assumes controls arrive registered from the front end on the core clock.
`timescale 1ns/10ps
`default_nettype none
module conv_core_model (
	input  wire logic                     i_pd,   // Power-down from the front end
	input  wire logic [11:0]              i_code, // Code from the front end
	output logic [11:0]                   o_level // Code the output stage shows
);
	// Powered-down core shows no code
	assign o_level = i_pd ? 12'h000 : i_code;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the converter register front end, random codes from a fixed seed.
// Assumes the package, the design and the core model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic                     i_clk_sys;
	logic                     i_nrst;
	conv_reg_pkg::sfr_req_s   i_req;
	logic [7:0]               rdata, h, l, r, v;
	logic                     rvalid;
	conv_reg_pkg::conv_ctrl_s conv;
	logic [11:0]              level, e;
	logic [31:0]              seed;
	int                       n_fail, checks;
	conv_reg_if i_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(i_req), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_conv(conv));
	conv_core_model i_core (.i_pd(conv.power_down), .i_code(conv.code), .o_level(level));
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [11:0] code_of(input logic [7:0] hi, input logic [7:0] lo, input logic bm);
		return bm ? {lo, 4'h0} : {hi[3:0], lo};
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Each bus task starts and ends 1 ns after a rising edge; the idle cycle
	// behind each request keeps a strobe from being lowered and raised at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_req = {1'b1, 1'b0, a, d};
		@(posedge i_clk_sys);
		#1 i_req = '0;
		@(posedge i_clk_sys);
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		i_req = {1'b0, 1'b1, a, 8'h00};
		@(posedge i_clk_sys);
		#1 i_req = '0;
		chk("rvalid", rvalid, 1'b1);
		r = rdata;
		@(posedge i_clk_sys);
		#1 chk("rvalid end", rvalid, 1'b0);
		chk("rdata end", rdata, 8'h00);
	endtask
	task automatic complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Tests need about 200 cycles; the margin only catches a hang
	initial begin
		#20000 n_fail++;
		complete_run();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		i_req = '0;
		i_nrst = 1'b0;
		seed = 32'h31;
		repeat (12) @(posedge i_clk_sys);
		#1 i_nrst = 1'b1;
		for (int a = 8'hfa; a <= 8'hfe; a++) begin
			rd(a[7:0]);
			chk("reset read", r, 8'h00);
		end
		chk("level at reset", level, 12'h000);
		$display("test reset done");
		wr(8'hfd, 8'he3);
		rd(8'hfd);
		chk("control read", r, 8'h03);
		for (int i = 0; i < 4; i++) begin
			v = {3'b000, i[1], 1'b0, i[0], 2'b11};
			wr(8'hfd, v);
			chk("pin", conv.pin_alternate, v[4]);
			chk("range", conv.range_supply, v[2]);
		end
		$display("test control done");
		e = 12'h000;
		for (int i = 0; i < 24; i++) begin
			seed = xorshift(seed);
			h = (i == 0) ? 8'hff : seed[7:0];
			l = seed[15:8];
			wr(8'hfc, h);
			chk("code after high", conv.code, e);
			wr(8'hfb, l);
			e = code_of(h, l, 1'b0);
			chk("code", conv.code, e);
			chk("level", level, e);
			rd(8'hfc);
			chk("high read", r, {4'h0, h[3:0]});
		end
		$display("test twelve bit done");
		wr(8'hfd, 8'h0b);
		chk("mode change", conv.code, e);
		wr(8'hfc, seed[23:16]);
		wr(8'hfb, seed[31:24]);
		chk("byte code", conv.code, code_of(8'h00, seed[31:24], 1'b1));
		$display("test byte mode done");
		i_nrst = 1'b0;
		@(posedge i_clk_sys);
		#1 chk("code in reset", conv.code, 12'h000);
		chk("power in reset", conv.power_down, 1'b1);
		i_nrst = 1'b1;
		rd(8'hfd);
		chk("control after reset", r, 8'h00);
		rd(8'hfb);
		chk("low after reset", r, 8'h00);
		$display("test reset again done");
		wr(8'hfd, 8'h01);
		wr(8'hfb, 8'h5a);
		chk("cleared code", conv.code, 12'h000);
		rd(8'hfb);
		chk("cleared low", r, 8'h00);
		wr(8'hfd, 8'h00);
		chk("power down", conv.power_down, 1'b1);
		$display("test clear done");
		complete_run();
	end
endmodule
`default_nettype wire
